/* File: shared/clh_pkg.sv */
/*
  constants and types for the character display host port controller.
  assumes a 25 MHz system clock and a display module on a strobe-paced
  parallel bus with register select, read/write select and strobe.
*/
package clh_pkg;
  // ==========================================================
  // clock and pin timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_AS_NS       = 40;
  localparam int T_PWEH_NS     = 230;
  localparam int T_CYCE_NS     = 500;
  localparam int T_DDR_NS      = 120;
  localparam int SYNC_LAT      = 4;
  localparam int AS_RAW   = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PW_RAW   = (T_PWEH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RAW  = (T_CYCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DDR_RAW  = (T_DDR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AS_CYC   = (AS_RAW < 1) ? 1 : AS_RAW;
  localparam int PW_CYC   = (PW_RAW < 1) ? 1 : PW_RAW;
  localparam int RDH_RAW  = DDR_RAW + SYNC_LAT;
  localparam int RDH_CYC  = (RDH_RAW > PW_CYC) ? RDH_RAW : PW_CYC;
  localparam int LOW_RAW  = CYC_RAW - PW_CYC - AS_CYC;
  localparam int LOW_CYC  = (LOW_RAW < 1) ? 1 : LOW_RAW;
  localparam int CNT_W    = 5;

  // ==========================================================
  // command word layout and bus fields
  localparam int FE_RS    = 9;
  localparam int FE_RW    = 8;
  localparam int FE_W     = 10;
  localparam int BUSY_BIT = 7;

  // ==========================================================
  // display text ram address map
  localparam logic [7:0] LINE1_FIRST = 8'h00;
  localparam logic [7:0] LINE1_LAST  = 8'h13;
  localparam logic [7:0] LINE2_FIRST = 8'h40;
  localparam logic [7:0] LINE2_LAST  = 8'h53;
  localparam logic [7:0] RAM1_LAST   = 8'h27;
  localparam logic [7:0] RAM2_LAST   = 8'h67;

  // ==========================================================
  // state types
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW} clh_phase_t;

  typedef struct packed {
    clh_phase_t       phase;
    logic [CNT_W-1:0] cnt;
    logic             polling;
    logic             poll_ok;
    logic             nib;
    logic             rs;
    logic             rw;
    logic [7:0]       data;
    logic [7:0]       acc;
    logic             pin_rs;
    logic             pin_rw;
    logic             en;
    logic             oe;
    logic [7:0]       dout;
    logic [7:0]       rd_data;
    logic             rd_valid;
    logic             done;
    logic [1:0]       xfer_rises;
    logic [7:0]       s1;
    logic [7:0]       s2;
    logic [7:0]       s3;
    logic [7:0]       stable;
  } clh_host_t;
endpackage

/* File: design/clh_host.sv */
/*
  host controller for a character display module parallel port, with a
  command fifo in front of it.
  assumes the module sits on the pins directly, the interface width mode
  does not change while a command is in flight, and the pin bus level is
  resolved outside from the enables.
*/
// Summary of operation
// [RULE1] a write with register select low puts the byte into the module as a command.
// [RULE2] a read with register select low returns busy flag and address counter.
// [RULE3] register select high steers reads and writes to the module data register.
// [RULE4] read/write low means host drives the bus, high means module drives it.
// [RULE5] every transfer is started by one pulse of the operation strobe.
// [RULE6] the busy indication comes back on the top data line during a status read.
// [RULE7] in 4-bit mode only the upper four lines are used, the lower four stay idle.
// [RULE8] in 4-bit mode a byte needs exactly two strobed nibble transfers.
// [RULE9] in 4-bit mode the high nibble goes first and the low nibble second.
// [RULE10] in 8-bit mode a byte moves in one strobed transfer on all eight lines.
// [RULE11] line one positions sit at 00h to 13h, line two at 40h to 53h.
// [RULE12] text ram exists only at 00h to 27h and 40h to 67h; the display model keeps all 128 addresses and counts past 27h.
// [RULE13] the host polls status until not busy before each command or data transfer.
// [RULE14] register select and read/write are stable before the strobe rises until it falls.
`timescale 1ns/1ps

// ==========================================================
// command fifo
module clh_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } clh_fifo_st_t;

  clh_fifo_st_t   st_r;
  clh_fifo_st_t   st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic           push;
  logic           pop;

  assign in_ready  = (st_r.count != FULL);
  assign out_valid = (st_r.count != '0);
  assign out_data  = mem_r[st_r.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wr_ptr = (st_r.wr_ptr == LAST) ? '0 : st_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd_ptr = (st_r.rd_ptr == LAST) ? '0 : st_r.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[st_r.wr_ptr] <= in_data;
    end
  end
endmodule

// ==========================================================
// host port engine
module clh_host #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // user command side
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_rs,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_data,
  input  wire logic       four_bit_mode,
  // user answer side
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            ctrl_busy,
  // display pins
  output logic            register_select,
  output logic            read_select,
  output logic            op_strobe,
  input  wire logic [3:0] high_nibble_lines_rx,
  output logic [3:0]      high_nibble_lines_tx,
  output logic            high_nibble_lines_oe,
  input  wire logic [3:0] low_nibble_lines_rx,
  output logic [3:0]      low_nibble_lines_tx,
  output logic            low_nibble_lines_oe
);
  clh_pkg::clh_host_t          r;
  clh_pkg::clh_host_t          n;
  logic                        f_valid;
  logic                        f_ready;
  logic [clh_pkg::FE_W-1:0]    f_data;
  logic                        cnt_end;

  // ==========================================================
  // command buffer
  clh_fifo #(
    .WIDTH (clh_pkg::FE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   ({cmd_rs, cmd_read, cmd_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  assign f_ready = (r.phase == clh_pkg::ST_IDLE);
  assign cnt_end = (r.cnt == clh_pkg::CNT_W'(1));

  // ==========================================================
  // next state
  always_comb begin
    n          = r;
    n.rd_valid = 1'b0;
    n.done     = 1'b0;
    // pin inputs: three stages, change taken once stages two and three agree
    n.s1       = {high_nibble_lines_rx, low_nibble_lines_rx};
    n.s2       = r.s1;
    n.s3       = r.s2;
    if (r.s2 == r.s3) begin
      n.stable = r.s3;
    end
    case (r.phase)
      clh_pkg::ST_IDLE: begin
        if (f_valid) begin
          n.rs         = f_data[clh_pkg::FE_RS];
          n.rw         = f_data[clh_pkg::FE_RW];
          n.data       = f_data[7:0];
          n.polling    = 1'b1; // [RULE13]
          n.poll_ok    = 1'b0;
          n.nib        = 1'b0;
          n.xfer_rises = 2'h0;
          n.pin_rs     = 1'b0; // [RULE2]
          n.pin_rw     = 1'b1;
          n.oe         = 1'b0; // [RULE4]
          n.phase      = clh_pkg::ST_SETUP;
          n.cnt        = clh_pkg::CNT_W'(clh_pkg::AS_CYC);
        end
      end
      clh_pkg::ST_SETUP: begin
        if (cnt_end) begin
          n.en    = 1'b1; // [RULE5] [RULE14]
          n.phase = clh_pkg::ST_HIGH;
          n.cnt   = r.pin_rw ? clh_pkg::CNT_W'(clh_pkg::RDH_CYC)
                             : clh_pkg::CNT_W'(clh_pkg::PW_CYC);
          if (!r.polling) begin
            n.xfer_rises = r.xfer_rises + 2'h1;
          end
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      clh_pkg::ST_HIGH: begin
        if (cnt_end) begin
          n.en    = 1'b0;
          n.phase = clh_pkg::ST_LOW;
          n.cnt   = clh_pkg::CNT_W'(clh_pkg::LOW_CYC);
          if (r.pin_rw) begin
            if (!four_bit_mode) begin
              n.acc = r.stable; // [RULE10]
            end else if (!r.nib) begin
              n.acc[7:4] = r.stable[7:4]; // [RULE9]
            end else begin
              n.acc[3:0] = r.stable[7:4]; // [RULE7]
            end
          end
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      clh_pkg::ST_LOW: begin
        if (!cnt_end) begin
          n.cnt = r.cnt - 1'b1;
        end else if (four_bit_mode && !r.nib) begin
          n.nib   = 1'b1; // [RULE8]
          n.phase = clh_pkg::ST_SETUP;
          n.cnt   = clh_pkg::CNT_W'(clh_pkg::AS_CYC);
          if (!r.pin_rw) begin
            n.dout = {r.data[3:0], 4'h0}; // [RULE9]
          end
        end else begin
          n.nib   = 1'b0;
          n.phase = clh_pkg::ST_SETUP;
          n.cnt   = clh_pkg::CNT_W'(clh_pkg::AS_CYC);
          if (r.polling) begin
            if (!r.acc[clh_pkg::BUSY_BIT]) begin // [RULE6] [RULE13]
              n.polling = 1'b0;
              n.poll_ok = 1'b1;
              n.pin_rs  = r.rs; // [RULE1] [RULE3]
              n.pin_rw  = r.rw;
              n.oe      = !r.rw; // [RULE4]
              n.dout    = four_bit_mode ? {r.data[7:4], 4'h0} : r.data; // [RULE9] [RULE10]
            end
          end else begin
            n.phase    = clh_pkg::ST_IDLE;
            n.oe       = 1'b0;
            n.done     = 1'b1;
            n.rd_valid = r.pin_rw;
            if (r.pin_rw) begin
              n.rd_data = r.acc;
            end
          end
        end
      end
      default: begin
        n.phase = clh_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs
  assign rd_valid             = r.rd_valid;
  assign rd_data              = r.rd_data;
  assign ctrl_busy            = (r.phase != clh_pkg::ST_IDLE);
  assign register_select      = r.pin_rs;
  assign read_select          = r.pin_rw;
  assign op_strobe            = r.en;
  assign high_nibble_lines_tx = r.dout[7:4];
  assign low_nibble_lines_tx  = r.dout[3:0];
  assign high_nibble_lines_oe = r.oe;
  assign low_nibble_lines_oe  = r.oe && !four_bit_mode; // [RULE7]

  // ==========================================================
  // checks
  a_read_no_drive: assert property (@(posedge clk) disable iff (!arst_n) // [RULE4]
    read_select |-> !high_nibble_lines_oe && !low_nibble_lines_oe)
    else $error("host drives bus during read");
  a_write_drives: assert property (@(posedge clk) disable iff (!arst_n) // [RULE4]
    op_strobe && !read_select |-> high_nibble_lines_oe)
    else $error("host not driving bus during write strobe");
  a_low_lines_idle: assert property (@(posedge clk) disable iff (!arst_n) // [RULE7]
    four_bit_mode |-> !low_nibble_lines_oe)
    else $error("low lines driven in 4-bit mode");
  a_strobe_width: assert property (@(posedge clk) disable iff (!arst_n) // [RULE5]
    $rose(op_strobe) |-> op_strobe[*6] ##1 1)
    else $error("strobe pulse too short");
  a_strobe_gap: assert property (@(posedge clk) disable iff (!arst_n) // [RULE5]
    $fell(op_strobe) |-> !op_strobe[*7])
    else $error("strobe cycle too short");
  a_ctl_stable: assert property (@(posedge clk) disable iff (!arst_n) // [RULE14]
    (op_strobe || $rose(op_strobe)) |-> $stable(register_select) && $stable(read_select))
    else $error("select lines move around strobe");
  a_nibble_pair: assert property (@(posedge clk) disable iff (!arst_n) // [RULE8]
    r.done && four_bit_mode |-> r.xfer_rises == 2'h2)
    else $error("4-bit byte not two strobes");
  a_byte_single: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
    r.done && !four_bit_mode |-> r.xfer_rises == 2'h1)
    else $error("8-bit byte not one strobe");
  a_high_first: assert property (@(posedge clk) disable iff (!arst_n) // [RULE9]
    $rose(op_strobe) && !read_select && four_bit_mode && !r.nib
      |-> high_nibble_lines_tx == r.data[7:4])
    else $error("high nibble not sent first");
  a_busy_wait: assert property (@(posedge clk) disable iff (!arst_n) // [RULE13]
    $rose(op_strobe) && !r.polling && !r.nib |-> r.poll_ok && !r.acc[clh_pkg::BUSY_BIT])
    else $error("transfer without busy clear");

  c_write_4bit: cover property (@(posedge clk) disable iff (!arst_n)
    r.done && four_bit_mode && !r.pin_rw);
  c_read_8bit: cover property (@(posedge clk) disable iff (!arst_n)
    rd_valid && !four_bit_mode);
  c_busy_retry: cover property (@(posedge clk) disable iff (!arst_n)
    r.polling && r.phase == clh_pkg::ST_LOW && cnt_end && r.acc[clh_pkg::BUSY_BIT]);
  c_fifo_full: cover property (@(posedge clk) disable iff (!arst_n)
    cmd_valid && !cmd_ready);
endmodule

/* File: bench/clh_lcd_model.sv */
/*
  behavioural model of the character display module on the host pins.
  assumes strobe-paced transfers from the clh_host controller and one
  resolved wire per data line, computed here from both parties' enables.
*/
`timescale 1ns/1ps

// ==========================================================
// display module model
module clh_lcd_model (
  // host pins
  input  wire logic       register_select,
  input  wire logic       read_select,
  input  wire logic       op_strobe,
  input  wire logic [3:0] hi_tx,
  input  wire logic       hi_oe,
  input  wire logic [3:0] lo_tx,
  input  wire logic       lo_oe,
  // mode and pacing
  input  wire logic       four_bit_mode,
  input  wire logic [31:0] busy_polls,
  // resolved data lines
  output logic [3:0]      hi_bus,
  output logic [3:0]      lo_bus
);
  logic [7:0] ram [0:127];
  logic [7:0] ir, wr, rb, flt;
  logic [6:0] ac;
  logic       nib, drv, rs_q, rw_q;
  int         busy_left, n_strobe, n_viol, busy_seen;

  assign hi_bus = hi_oe ? hi_tx : drv ? ((four_bit_mode && nib) ? rb[3:0] : rb[7:4]) : flt[7:4];
  assign lo_bus = lo_oe ? lo_tx : (drv && !four_bit_mode) ? rb[3:0] : flt[3:0];

  initial begin
    for (int i = 0; i < 128; i++) ram[i] = 8'h00;
    {ir, wr, rb, ac, nib, drv, rs_q, rw_q} = '0;
    flt = 8'hA5;
    {busy_left, n_strobe, n_viol, busy_seen} = '0;
  end

  always @(posedge op_strobe) begin
    n_strobe++;
    rs_q = register_select;
    rw_q = read_select;
    if (rw_q && !nib) rb = rs_q ? ram[ac] : {busy_left > 0, ac};
    if (rw_q) begin
      #110 drv = 1'b1;
      if (hi_oe) n_viol++;
    end
  end

  always @(negedge op_strobe) if (n_strobe > 0) begin // skip the settle from unknown at start
    if (register_select !== rs_q || read_select !== rw_q) n_viol++;
    flt = ~{hi_bus, lo_bus};
    drv = 1'b0;
    if (!rw_q) begin
      if (hi_oe !== 1'b1 || (!four_bit_mode && lo_oe !== 1'b1)) n_viol++;
      if (busy_left > 0) n_viol++;
      wr = four_bit_mode ? (nib ? {wr[7:4], hi_tx} : {hi_tx, 4'h0}) : {hi_tx, lo_tx};
    end
    if (four_bit_mode && !nib) begin
      nib = 1'b1;
    end else begin
      nib = 1'b0;
      if (rw_q && !rs_q) begin
        if (busy_left > 0) begin
          busy_left--;
          busy_seen++;
        end
      end else if (rw_q) begin
        ac++;
      end else if (rs_q) begin
        ram[ac] = wr;
        ac++;
        busy_left = busy_polls;
      end else begin
        ir = wr;
        if (wr[7]) ac = wr[6:0];
        busy_left = busy_polls;
      end
    end
  end

  always @(posedge lo_oe) if (four_bit_mode) n_viol++;
endmodule

/* File: bench/tb_clh_host.sv */
/*
  self-checking testbench for clh_host against the display module model.
  assumes the package clh_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps

// ==========================================================
// testbench top
module tb_clh_host;
  logic       clk, arst_n, cmd_valid, cmd_rs, cmd_read, four_bit_mode;
  logic [7:0] cmd_data, rd_data, q;
  logic       cmd_ready, rd_valid, ctrl_busy, register_select, read_select, op_strobe;
  logic [3:0] hi_tx, lo_tx, hi_bus, lo_bus;
  logic       hi_oe, lo_oe;
  int         busy_polls, n_errors, samples_checked;
  logic [7:0] addrs [6] = '{8'h00, 8'h13, 8'h27, 8'h40, 8'h53, 8'h67};

  clh_host u_dut (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_rs(cmd_rs), .cmd_read(cmd_read), .cmd_data(cmd_data), .four_bit_mode(four_bit_mode),
    .rd_valid(rd_valid), .rd_data(rd_data), .ctrl_busy(ctrl_busy),
    .register_select(register_select), .read_select(read_select), .op_strobe(op_strobe),
    .high_nibble_lines_rx(hi_bus), .high_nibble_lines_tx(hi_tx), .high_nibble_lines_oe(hi_oe),
    .low_nibble_lines_rx(lo_bus), .low_nibble_lines_tx(lo_tx), .low_nibble_lines_oe(lo_oe));

  clh_lcd_model u_lcd (.register_select(register_select), .read_select(read_select),
    .op_strobe(op_strobe), .hi_tx(hi_tx), .hi_oe(hi_oe), .lo_tx(lo_tx), .lo_oe(lo_oe),
    .four_bit_mode(four_bit_mode), .busy_polls(busy_polls), .hi_bus(hi_bus), .lo_bus(lo_bus));

  always #20 clk = ~clk;

  task summarize;
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask

  // waits for the engine to settle, keeping any read byte
  task wait_idle(input int bound);
    int k, s;
    k = 0;
    s = 0;
    while (s < 6 && k < bound) begin
      @(posedge clk);
      k++;
      s = (ctrl_busy === 1'b0) ? s + 1 : 0;
      if (rd_valid === 1'b1) q = rd_data;
    end
    if (k >= bound) begin
      $display("Error at %0t: engine never idle", $time);
      n_errors++;
      summarize();
    end
  endtask

  task do_cmd(input logic rs, input logic rd, input logic [7:0] d);
    int k;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_rs    <= rs;
    cmd_read  <= rd;
    cmd_data  <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 50);
    if (cmd_ready !== 1'b1) begin
      $display("Error at %0t: request never taken", $time);
      n_errors++;
      summarize();
    end
    cmd_valid <= 1'b0;
    q = 8'hxx;
    wait_idle(3000);
  endtask

  // ==========================================================
  // scenarios
  task t_map;
    busy_polls = 1;
    foreach (addrs[i]) begin
      do_cmd(1'b0, 1'b0, {1'b1, addrs[i][6:0]});
      chk(u_lcd.ir, {1'b1, addrs[i][6:0]});
      do_cmd(1'b1, 1'b0, addrs[i] ^ 8'hA5);
    end
    foreach (addrs[i]) begin
      do_cmd(1'b0, 1'b0, {1'b1, addrs[i][6:0]});
      do_cmd(1'b1, 1'b1, 8'h00);
      chk(q, addrs[i] ^ 8'hA5);
      do_cmd(1'b0, 1'b1, 8'h00);
      chk(q, {1'b0, addrs[i][6:0] + 7'h01});
    end
  endtask

  task t_width;
    int s;
    busy_polls = 0;
    @(posedge clk);
    four_bit_mode <= 1'b1;
    s = u_lcd.n_strobe;
    do_cmd(1'b0, 1'b0, 8'h93);
    chk(8'(u_lcd.n_strobe - s), 8'h04);
    chk(u_lcd.ir, 8'h93);
    do_cmd(1'b1, 1'b0, 8'h5A);
    do_cmd(1'b0, 1'b0, 8'h93);
    do_cmd(1'b1, 1'b1, 8'h00);
    chk(q, 8'h5A);
    do_cmd(1'b0, 1'b1, 8'h00);
    chk(q, 8'h14);
    @(posedge clk);
    four_bit_mode <= 1'b0;
    s = u_lcd.n_strobe;
    do_cmd(1'b1, 1'b0, 8'h3C);
    chk(8'(u_lcd.n_strobe - s), 8'h02);
    chk(u_lcd.ram[8'h14], 8'h3C);
  endtask

  task t_fifo;
    int i, k;
    logic full;
    busy_polls = 2;
    full = 1'b0;
    do_cmd(1'b0, 1'b0, 8'h80);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_rs    <= 1'b1;
    cmd_read  <= 1'b0;
    cmd_data  <= 8'h00;
    i = 0;
    k = 0;
    while (i < 12 && k < 5000) begin
      @(posedge clk);
      k++;
      if (cmd_ready === 1'b1) begin
        i++;
        cmd_data <= 8'(i);
      end else begin
        full = 1'b1;
      end
    end
    cmd_valid <= 1'b0;
    wait_idle(8000);
    chk(8'(i), 8'h0C);
    chk({7'h00, full}, 8'h01);
    for (int j = 0; j < 12; j++) chk(u_lcd.ram[j], 8'(j));
  endtask

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {cmd_valid, cmd_rs, cmd_read, four_bit_mode} = '0;
    cmd_data = 8'h00;
    busy_polls = 0;
    n_errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_map();
    t_width();
    t_fifo();
    chk(8'(u_lcd.n_viol), 8'h00);
    chk({7'h00, u_lcd.busy_seen > 0}, 8'h01);
    summarize();
  end
endmodule
